// >>> rtl/buzzer_cfg.svh
// Purpose: Offsets, field positions, reset values and timing figures of the buzzer block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Byte address of a register is four times its index
`ifndef BUZZER_CFG_SVH
`define BUZZER_CFG_SVH

// Register indices and byte addresses
`define BUZ_CTRL_IDX         20'h0ff44
`define BUZ_TONE_IDX         20'h0ff45
`define BUZ_ADDR_W           20
`define BUZ_CTRL_ADDR        (`BUZ_CTRL_IDX << 2)
`define BUZ_TONE_ADDR        (`BUZ_TONE_IDX << 2)

// buzzer_control fields
`define CTRL_TONE_EN_BIT     0
`define CTRL_ENV_EN_BIT      1
`define CTRL_ENV_RST_BIT     2
`define CTRL_STEP_TIME_BIT   3
`define CTRL_WIDTH_BIT       4
`define CTRL_TRIG_BIT        5
`define CTRL_STOP_BIT        6

// buzzer_tone_select fields
`define TONE_DIV_LSB         0
`define TONE_DUTY_LSB        4

// Reset values
`define CTRL_RESET           8'h00
`define DIV_RESET            3'h0
`define DUTY_RESET           3'h0

// Timing in ns and the clock period
`define CLK_PERIOD_NS        10
`define ENV_STEP_LONG_NS     125000000
`define ENV_STEP_SHORT_NS    62500000
`define ONESHOT_LONG_NS      125000000
`define ONESHOT_SHORT_NS     31250000

// AXI responses
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// >>> rtl/buzzer_pkg.sv
// Purpose: Types shared by the buzzer files
// Assumes: Nothing beyond the config header
// Notes:   Constants live in buzzer_cfg.svh
package buzzer_pkg;
	typedef logic [2:0] code3_t;
	typedef enum {ONESHOT_IDLE, ONESHOT_BUSY} oneshot_state_t;
endpackage : buzzer_pkg

// >>> rtl/tone_if.sv
// Purpose: Carrier between the buzzer control and its tone generator
// Assumes: Single clock domain
// Notes:   Oscillator edges are one-cycle pulses
`timescale 1ns/100ps
interface tone_if;
	import buzzer_pkg::*;
	code3_t divider_sel;
	code3_t duty_level;
	logic   osc_rise;
	logic   osc_fall;
	logic   tone;
	modport ctl (output divider_sel, output duty_level, output osc_rise, output osc_fall,
		input tone);
	modport gen (input divider_sel, input duty_level, input osc_rise, input osc_fall,
		output tone);
endinterface : tone_if

// >>> rtl/tone_gen.sv
// Purpose: Square wave with selectable period and duty from the oscillator edges
// Assumes: Oscillator edges arrive as one-cycle pulses
// Notes:   Low divider codes count both edges, so each period is 16 to 28 steps
`timescale 1ns/100ps
module tone_gen
	import buzzer_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	tone_if.gen       tif
);
	// Period in counting steps: 16, 20, 24 or 28
	function automatic logic [4:0] period_of(input code3_t c);
		case (c[1:0])
			2'h0:    period_of = 5'h10;
			2'h1:    period_of = 5'h14;
			2'h2:    period_of = 5'h18;
			default: period_of = 5'h1c;
		endcase
	endfunction : period_of

	// High steps: 8 or 12 at level 0, one less for each further level
	function automatic logic [4:0] high_of(input code3_t c, input code3_t lvl);
		high_of = (c[1] ? 5'h0c : 5'h08) - {2'h0, lvl};
	endfunction : high_of

	logic [4:0] cnt_q;
	logic       tone_q;
	wire        step     = tif.divider_sel[2] ? tif.osc_rise : (tif.osc_rise | tif.osc_fall);
	wire [4:0]  last_cnt = period_of(tif.divider_sel) - 5'h01;
	wire [4:0]  high_cnt = high_of(tif.divider_sel, tif.duty_level);

	// Period counter; a new divider code takes effect at once, a count past its new end wraps at the next step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 5'h00;
		end else if (step) begin
			cnt_q <= (cnt_q >= last_cnt) ? 5'h00 : cnt_q + 5'h01;
		end
	end

	// Duty compare, registered so the pin sees no decode glitch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tone_q <= 1'b0;
		end else begin
			tone_q <= (cnt_q < high_cnt);
		end
	end

	assign tif.tone = tone_q;
endmodule : tone_gen

// >>> rtl/buzzer_envelope_oneshot.sv
// Purpose: Buzzer tone control with envelope and one-shot, AXI4-Lite register slave
// Assumes: Oscillator input synchronous to aclk; aresetn synchronous, active low
// Notes:   Long timers are parameters so a simulation can shorten them
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "buzzer_cfg.svh"
module buzzer_envelope_oneshot
	import buzzer_pkg::*;
#(
	parameter int ENV_LONG_CYC   = `ENV_STEP_LONG_NS / `CLK_PERIOD_NS,
	parameter int ENV_SHORT_CYC  = `ENV_STEP_SHORT_NS / `CLK_PERIOD_NS,
	parameter int SHOT_LONG_CYC  = `ONESHOT_LONG_NS / `CLK_PERIOD_NS,
	parameter int SHOT_SHORT_CYC = `ONESHOT_SHORT_NS / `CLK_PERIOD_NS,
	parameter int TIMER_W        = 24
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite slave
	input  wire logic [`BUZ_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output wire logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output wire logic                   s_axi_wready,
	output wire logic [1:0]             s_axi_bresp,
	output wire logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`BUZ_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output wire logic                   s_axi_arready,
	output wire logic [31:0]            s_axi_rdata,
	output wire logic [1:0]             s_axi_rresp,
	output wire logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Oscillator and pin
	input  wire logic                   low_speed_osc_clock,
	output wire logic                   tone_output_pin
);
	localparam logic [TIMER_W-1:0] ENV_LONG_LAST   = TIMER_W'(ENV_LONG_CYC - 1);
	localparam logic [TIMER_W-1:0] ENV_SHORT_LAST  = TIMER_W'(ENV_SHORT_CYC - 1);
	localparam logic [TIMER_W-1:0] SHOT_LONG_LAST  = TIMER_W'(SHOT_LONG_CYC - 1);
	localparam logic [TIMER_W-1:0] SHOT_SHORT_LAST = TIMER_W'(SHOT_SHORT_CYC - 1);

	// Register bits
	logic           tone_en_q;
	logic           env_en_q;
	logic           step_time_q;
	logic           width_q;
	code3_t         div_sel_q;
	code3_t         duty_sel_q;
	oneshot_state_t shot_state_q;
	logic [TIMER_W-1:0] shot_cnt_q;
	logic [TIMER_W-1:0] env_cnt_q;
	code3_t         env_lvl_q;
	logic           osc_q;
	logic           pin_q;

	// Bus slave state
	logic                   aw_got_q;
	logic                   w_got_q;
	logic [`BUZ_ADDR_W-1:0] awaddr_q;
	logic [7:0]             wbyte_q;
	logic                   wlane_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	logic                   rvalid_q;
	logic [31:0]            rdata_q;
	logic [1:0]             rresp_q;

	// Register decode shared by the write and read paths
	function automatic logic hit_ctrl(input logic [`BUZ_ADDR_W-1:0] a);
		hit_ctrl = (a == `BUZ_ADDR_W'(`BUZ_CTRL_ADDR));
	endfunction : hit_ctrl

	function automatic logic hit_tone(input logic [`BUZ_ADDR_W-1:0] a);
		hit_tone = (a == `BUZ_ADDR_W'(`BUZ_TONE_ADDR));
	endfunction : hit_tone

	// Handshakes: each channel accepted once until the response is taken
	// Ready drops while a response waits, so a second request simply stalls
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire  = s_axi_wvalid && s_axi_wready;
	wire ar_fire = s_axi_arvalid && s_axi_arready;

	// Write commits in the cycle both halves are held, address or data may come first
	wire                   aw_have  = aw_got_q || aw_fire;
	wire                   w_have   = w_got_q || w_fire;
	wire                   wr_go    = aw_have && w_have && !bvalid_q;
	wire [`BUZ_ADDR_W-1:0] wr_addr  = aw_got_q ? awaddr_q : s_axi_awaddr;
	wire [7:0]             wr_byte  = w_got_q ? wbyte_q : s_axi_wdata[7:0];
	wire                   wr_lane  = w_got_q ? wlane_q : s_axi_wstrb[0];
	wire                   wr_ctrl_hit = hit_ctrl(wr_addr);
	wire                   wr_tone_hit = hit_tone(wr_addr);
	wire                   wr_ctrl  = wr_go && wr_ctrl_hit && wr_lane;
	wire                   wr_tone  = wr_go && wr_tone_hit && wr_lane;

	// Write-side control strobes decoded from the written byte
	wire shot_busy = (shot_state_q == ONESHOT_BUSY);
	wire trig_wr   = wr_ctrl && wr_byte[`CTRL_TRIG_BIT];
	wire stop_wr   = wr_ctrl && wr_byte[`CTRL_STOP_BIT];
	wire rst_wr    = wr_ctrl && wr_byte[`CTRL_ENV_RST_BIT];
	wire trig_ok   = trig_wr && !tone_en_q && !stop_wr;

	// Read decode; write-only bits and unused bits read zero
	wire       rd_ctrl_hit = hit_ctrl(s_axi_araddr);
	wire       rd_tone_hit = hit_tone(s_axi_araddr);
	wire [7:0] ctrl_rd = {1'b0, 1'b0, shot_busy, width_q, step_time_q, 1'b0, env_en_q,
		tone_en_q};
	wire [7:0] tone_rd = {1'b0, duty_sel_q, 1'b0, div_sel_q};
	wire [7:0] rd_byte = rd_ctrl_hit ? ctrl_rd : (rd_tone_hit ? tone_rd : 8'h00);

	// Write channel holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wbyte_q  <= 8'h00;
			wlane_q  <= 1'b0;
		end else begin
			aw_got_q <= aw_have && !wr_go;
			w_got_q  <= w_have && !wr_go;
			if (aw_fire) awaddr_q <= s_axi_awaddr;
			if (w_fire) begin
				wbyte_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	// Response waits for bready; no new address or data is taken meanwhile
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `AXI_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_ctrl_hit || wr_tone_hit) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read channel: data captured on address accept, held until taken
	// Decode uses the live address, so it must stand until arready, as the bus asks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `AXI_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rresp_q  <= (rd_ctrl_hit || rd_tone_hit) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Plain control bits; a trigger write clears envelope enable whatever it carries
	// Restart and stop bits are strobes only and are never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tone_en_q   <= 1'(`CTRL_RESET >> `CTRL_TONE_EN_BIT);
			env_en_q    <= 1'b0;
			step_time_q <= 1'b0;
			width_q     <= 1'b0;
			div_sel_q   <= `DIV_RESET;
			duty_sel_q  <= `DUTY_RESET;
		end else begin
			if (wr_ctrl) begin
				tone_en_q   <= wr_byte[`CTRL_TONE_EN_BIT];
				env_en_q    <= wr_byte[`CTRL_ENV_EN_BIT] && !trig_wr;
				step_time_q <= wr_byte[`CTRL_STEP_TIME_BIT];
				width_q     <= wr_byte[`CTRL_WIDTH_BIT];
			end
			if (wr_tone) begin
				div_sel_q  <= wr_byte[`TONE_DIV_LSB +: 3];
				duty_sel_q <= wr_byte[`TONE_DUTY_LSB +: 3];
			end
		end
	end

	// One-shot: stop beats trigger, trigger beats expiry, retrigger reloads the timer
	// Busy stands for LAST+1 cycles from the edge after the accepted trigger write
	// A trigger is judged against the enable bit as it stood before the same write
	wire [TIMER_W-1:0] shot_last = width_q ? SHOT_LONG_LAST : SHOT_SHORT_LAST;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shot_state_q <= ONESHOT_IDLE;
			shot_cnt_q   <= '0;
		end else begin
			case (shot_state_q)
				ONESHOT_IDLE: begin
					shot_cnt_q <= '0;
					if (trig_ok) shot_state_q <= ONESHOT_BUSY;
				end
				ONESHOT_BUSY: begin
					if (stop_wr) begin
						shot_state_q <= ONESHOT_IDLE;
						shot_cnt_q   <= '0;
					end else if (trig_ok) begin
						shot_cnt_q <= '0;
					end else if (shot_cnt_q >= shot_last) begin
						shot_state_q <= ONESHOT_IDLE;
						shot_cnt_q   <= '0;
					end else begin
						shot_cnt_q <= shot_cnt_q + 1'b1;
					end
				end
				default: begin
					shot_state_q <= ONESHOT_IDLE;
					shot_cnt_q   <= '0;
				end
			endcase
		end
	end

	// Envelope: restart only counts while the envelope is on, level saturates at minimum
	// Level zero is the loudest; one step every LAST+1 cycles, floor at level seven
	// A restart together with a disable leaves level zero either way
	wire [TIMER_W-1:0] env_last = step_time_q ? ENV_LONG_LAST : ENV_SHORT_LAST;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			env_cnt_q <= '0;
			env_lvl_q <= 3'h0;
		end else if (!env_en_q || (rst_wr && env_en_q)) begin
			env_cnt_q <= '0;
			env_lvl_q <= 3'h0;
		end else if (env_cnt_q >= env_last) begin
			env_cnt_q <= '0;
			if (env_lvl_q != 3'h7) env_lvl_q <= env_lvl_q + 3'h1;
		end else begin
			env_cnt_q <= env_cnt_q + 1'b1;
		end
	end

	// Oscillator edge detect; the input is already synchronous to aclk
	// A false edge right after reset only shifts the tone phase, which nothing relies on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= low_speed_osc_clock;
		end
	end

	tone_if tif ();
	assign tif.divider_sel = div_sel_q;
	assign tif.duty_level  = env_en_q ? env_lvl_q : duty_sel_q;
	assign tif.osc_rise    = low_speed_osc_clock && !osc_q;
	assign tif.osc_fall    = !low_speed_osc_clock && osc_q;

	tone_gen u_tone (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (tif)
	);

	// Pin gate is not aligned to the tone phase, so a short first or last pulse can
	// appear; the external pin data bit must be zero for this level to reach the pad
	// Gate and tone are both registered, so the pin changes only on aclk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= tif.tone && (tone_en_q || shot_busy);
		end
	end

	assign tone_output_pin = pin_q;
endmodule : buzzer_envelope_oneshot

// >>> tb/buzzer_envelope_oneshot_chk.sv
// Purpose: Port assertions for the buzzer block
// Assumes: One clock, aresetn synchronous and active low
// Notes:   Covers the AXI handshakes and the tone pin
`timescale 1ns/100ps
module buzzer_envelope_oneshot_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        tone_output_pin
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Answers stand until the master takes them
	b_hold_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early");
	r_hold_a:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped early");
	r_done_a:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("Read data repeated");
	// Only one read may be outstanding
	ar_block_a:
		assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Address taken while data pending");
	r_answer_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	r_upper_a:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("Upper read bits set");
	w_answer_a:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> s_axi_bvalid)
		else $error("Write answer late");
	w_block_a:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write taken while response pending");
	pin_reset_a:
		assert property ($rose(aresetn) |-> !tone_output_pin)
		else $error("Pin high after reset");
	wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
	rd_seen_c: cover property (s_axi_rvalid && s_axi_rready);
	pin_rise_c: cover property ($rose(tone_output_pin));
endmodule : buzzer_envelope_oneshot_chk

// >>> tb/buzzer_model.sv
// Purpose: Buzzer stand-in that integrates drive time on the tone pin
// Assumes: Pin sampled on aclk
// Notes:   Loudness follows the count of high cycles
`timescale 1ns/100ps
module buzzer_model (
	input  wire logic aclk,
	input  wire logic tone_output_pin,
	output int        high_cnt
);
	// Port data bit taken as zero, so the pin carries the tone itself
	always_ff @(posedge aclk) begin
		high_cnt <= high_cnt + int'(tone_output_pin);
	end
endmodule : buzzer_model

// >>> tb/buzzer_envelope_oneshot_tb_top.sv
// Purpose: Register-level tests of the buzzer block
// Assumes: Timers shortened to 40, 20, 60 and 10 cycles
// Notes:   Duty is judged from high cycles in a window, so limits are loose
`timescale 1ns/100ps
`include "buzzer_cfg.svh"
module buzzer_envelope_oneshot_tb_top;
	localparam logic [19:0] CA = `BUZ_CTRL_ADDR;
	localparam logic [19:0] TA = `BUZ_TONE_ADDR;
	logic        aclk = 0, aresetn = 0, osc = 0;
	logic [19:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, pin;
	logic [1:0]  bresp, rresp;
	int          errors = 0, compares = 0, high_cnt;
	buzzer_envelope_oneshot #(.ENV_LONG_CYC(40), .ENV_SHORT_CYC(20), .SHOT_LONG_CYC(60),
		.SHOT_SHORT_CYC(10)) u_buzzer_envelope_oneshot (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.low_speed_osc_clock(osc), .tone_output_pin(pin));
	buzzer_model u_buzzer_model (.aclk(aclk), .tone_output_pin(pin), .high_cnt(high_cnt));
	// Clock and a fast oscillator, one edge per cycle to keep tone periods short
	always #5 aclk = ~aclk;
	always @(posedge aclk) osc <= ~osc;
	task automatic stop_test();
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic hung(input logic ok);
		if (!ok) begin
			errors++;
			stop_test();
		end
	endtask : hung
	// Ready is sampled at the falling edge; it is combinational, so it holds to the rise
	task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
		logic qa, qw, qb;
		logic [1:0] r;
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			qa = awvalid && awready;
			qw = wvalid && wready;
			qb = bvalid;
			r = bresp;
			@(posedge aclk);
			awvalid <= awvalid && !qa;
			wvalid <= wvalid && !qw;
			n++;
		end while (!qb && n < 60);
		bready <= 1'b0;
		@(posedge aclk); // One edge apart, so a next call never reassigns this strobe
		hung(qb);
		chk({32'h0, r}, {32'h0, e});
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
		logic qa, q;
		logic [33:0] g;
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			qa = arvalid && arready;
			q = rvalid;
			g = {rresp, rdata};
			@(posedge aclk);
			arvalid <= arvalid && !qa;
			n++;
		end while (!q && n < 60);
		rready <= 1'b0;
		@(posedge aclk); // One edge apart, so a next call never reassigns this strobe
		hung(q);
		chk(g, {e, 24'h0, d});
	endtask : rd
	// High cycles over a window; alignment costs up to one tone period
	task automatic meas(input int len, input int lo, input int hi);
		int h;
		h = high_cnt;
		repeat (len) @(posedge aclk);
		h = high_cnt - h;
		chk({33'h0, h >= lo && h <= hi}, 34'h1);
	endtask : meas
	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CA, 8'h00);
		rd(TA, 8'h00);
		wr(TA, 8'hff);
		rd(TA, 8'h77);
		wr(20'h0, 8'h01, 2'h2);
		rd(20'h0, 8'h00, 2'h2);
		wr(TA, 8'h00);
		wr(CA, 8'h01);
		meas(160, 70, 90);
		wr(CA, 8'h21);
		rd(CA, 8'h01);
		wr(TA, 8'h70);
		meas(160, 0, 20);
		wr(CA, 8'h03);
		meas(160, 30, 70);
		repeat (100) @(posedge aclk);
		meas(160, 0, 20);
		wr(CA, 8'h07);
		meas(160, 30, 70);
		rd(CA, 8'h03);
		// Long steps: level three to five here; short steps would sit at the floor
		wr(CA, 8'h0f);
		repeat (127) @(posedge aclk);
		meas(80, 12, 32);
		// Slowest divider, lowest duty: 5 of 28 steps, against 1 of 16 at code zero
		wr(CA, 8'h01);
		wr(TA, 8'h77);
		meas(168, 20, 40);
		wr(TA, 8'h70);
		wr(CA, 8'h00);
		repeat (8) @(posedge aclk);
		meas(160, 0, 0);
		wr(CA, 8'h1a);
		wr(CA, 8'h3a);
		rd(CA, 8'h38);
		meas(50, 1, 40);
		rd(CA, 8'h38);
		repeat (15) @(posedge aclk);
		rd(CA, 8'h18);
		wr(CA, 8'h30);
		repeat (40) @(posedge aclk);
		wr(CA, 8'h30);
		repeat (40) @(posedge aclk);
		rd(CA, 8'h30);
		repeat (25) @(posedge aclk);
		rd(CA, 8'h10);
		wr(CA, 8'h20);
		rd(CA, 8'h20);
		repeat (10) @(posedge aclk);
		rd(CA, 8'h00);
		wr(CA, 8'h30);
		wr(CA, 8'h50);
		rd(CA, 8'h10);
		wr(CA, 8'h70);
		rd(CA, 8'h10);
		// Reset in mid-run with bits set in both registers
		wr(CA, 8'h1b);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CA, 8'h00);
		rd(TA, 8'h00);
		wr(CA, 8'h00);
		stop_test();
	end
endmodule : buzzer_envelope_oneshot_tb_top
bind buzzer_envelope_oneshot buzzer_envelope_oneshot_chk u_buzzer_envelope_oneshot_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.tone_output_pin(tone_output_pin));
